/* bus_line_events.sv */
// Edge and start/stop detection on the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module bus_line_events
    import light_sensor_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    // Registered data level and events
    output logic sda_o,
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o
);
    logic scl_q, scl_d, sda_q, sda_d;
    logic rise_q, rise_d, fall_q, fall_d, start_q, start_d, stop_q, stop_d;

    always_comb begin
        scl_d = scl_i;
        sda_d = sda_i;
        rise_d = scl_i && !scl_q;
        fall_d = !scl_i && scl_q;
        // Data moving while the clock stays high frames a transfer
        start_d = scl_i && scl_q && sda_q && !sda_i;
        stop_d = scl_i && scl_q && !sda_q && sda_i;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (ce_i) begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            start_q <= start_d;
            stop_q <= stop_d;
        end
    end

    assign sda_o = sda_q;
    assign scl_rise_o = rise_q;
    assign scl_fall_o = fall_q;
    assign start_o = start_q;
    assign stop_o = stop_q;
endmodule // bus_line_events
`default_nettype wire

/* i2c_host_model.sv */
// Serial bus controller model that drives the clock and data lines
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Bus lines
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    // ------------------------------------------------------------
    // Line sequencing
    // ------------------------------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Every phase is at least 4 system cycles, so setup and hold hold
    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic start_cond();
        sda_o = 1'b1;
        gap(4);
        scl_o = 1'b1;
        gap(6);
        sda_o = 1'b0;
        gap(6);
        scl_o = 1'b0;
        gap(4);
    endtask
    task automatic stop_cond();
        sda_o = 1'b0;
        gap(4);
        scl_o = 1'b1;
        gap(6);
        sda_o = 1'b1;
        gap(6);
    endtask
    // A released line reads the pull-up or the target's drive
    task automatic put_bit(input logic b, output logic seen);
        sda_o = b;
        gap(4);
        scl_o = 1'b1;
        gap(4);
        seen = sda_line_i;
        gap(4);
        scl_o = 1'b0;
        gap(4);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(last, s);
    endtask
endmodule // i2c_host_model
`default_nettype wire

/* light_result_config_registers.sv */
// Result and range configuration registers with serial bus target
// Notes on behaviour
// R1: Result holds 4-bit exponent, 12-bit mantissa
// R2: Result is latest conversion, read-only
// R3: Mantissa is unsigned straight binary count
// R4: Each exponent step doubles 0.01 lux weight
// R5: Result exponent and mantissa reset to zero
// R6: Masked manual range reports exponent zero
// R7: Configuration resets to C810h
// R8: Configuration write aborts running conversion
// R9: New configuration may start fresh conversion
// R10: Range select in bits 15:12 picks scale
// R11: Range code 1100b selects automatic ranging
// R12: Host must not write reserved range codes
// R13: Configuration bit 8 read-only, others writable
// R14: Registers move high byte then low
// R15: Pointer kept until host writes new one
// R16: Writes to read-only bits silently ignored
`timescale 1ns/1ps
`default_nettype none
module light_result_config_registers
    import light_sensor_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Serial bus, data line is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Converter
    input wire logic conv_done_i,
    input wire logic [3:0] conv_exp_i,
    input wire logic [11:0] conv_mant_i,
    input wire logic conv_ovf_i,
    output logic conv_start_o,
    output logic conv_abort_o,
    output logic [3:0] conv_range_o,
    output logic conv_long_o,
    // Decoded light level in units of 0.01 lux
    output logic [LUX_W-1:0] lux_centi_o
);
    logic sda_s, scl_rise, scl_fall, bus_start, bus_stop;

    bus_line_events u_events (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_s),
        .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall),
        .start_o(bus_start),
        .stop_o(bus_stop)
    );

    // ------------------------------------------------------------------
    // Serial bus target
    // ------------------------------------------------------------------
    bus_state_e st_q, st_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d, hi_q, hi_d, ptr_q, ptr_d, lo_hold_q, lo_hold_d;
    logic [1:0] byte_idx_q, byte_idx_d;
    logic rx_full_q, rx_full_d, rw_q, rw_d, oe_n_q, oe_n_d, rd_lo_q, rd_lo_d;
    logic nack_q, nack_d, cfg_wr, ptr_wr;
    logic [15:0] rd_word, wdata;
    logic [15:0] result_q, result_d, cfg_q, cfg_d;

    assign wdata = {hi_q, shift_q};

    always_comb begin
        case (ptr_q)
            PTR_LIGHT_RESULT: rd_word = result_q;
            PTR_SENSOR_CONFIG: rd_word = cfg_q;
            default: rd_word = UNMAPPED_READ;
        endcase
    end

    always_comb begin
        st_d = st_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        rx_full_d = rx_full_q;
        rw_d = rw_q;
        byte_idx_d = byte_idx_q;
        hi_d = hi_q;
        ptr_d = ptr_q;
        lo_hold_d = lo_hold_q;
        oe_n_d = oe_n_q;
        rd_lo_d = rd_lo_q;
        nack_d = nack_q;
        cfg_wr = 1'b0;
        ptr_wr = 1'b0;
        if (bus_stop) begin
            st_d = ST_IDLE;
            oe_n_d = 1'b1;
        end else if (bus_start) begin
            st_d = ST_ADDR;
            bit_cnt_d = BIT_FIRST;
            rx_full_d = 1'b0;
            oe_n_d = 1'b1;
        end else begin
            case (st_q)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        rx_full_d = (bit_cnt_q == BIT_LAST);
                    end else if (scl_fall && rx_full_q) begin
                        rx_full_d = 1'b0;
                        if (st_q == ST_ADDR) begin
                            if (shift_q[7:1] == TARGET_ADDR) begin
                                st_d = ST_ACK;
                                oe_n_d = 1'b0;
                                rw_d = shift_q[0];
                                byte_idx_d = BYTE_PTR;
                                rd_lo_d = 1'b0;
                            end else begin
                                st_d = ST_IDLE;
                            end
                        end else begin
                            // R16: every data byte acknowledged
                            st_d = ST_ACK;
                            oe_n_d = 1'b0;
                            case (byte_idx_q)
                                BYTE_PTR: begin
                                    // R15: pointer only changes here
                                    ptr_d = shift_q;
                                    ptr_wr = 1'b1;
                                    byte_idx_d = BYTE_HI;
                                end
                                BYTE_HI: begin
                                    // R14: high byte arrives first
                                    hi_d = shift_q;
                                    byte_idx_d = BYTE_LO;
                                end
                                default: begin
                                    // R2: result pointer writes are dropped
                                    cfg_wr = (ptr_q == PTR_SENSOR_CONFIG);
                                    byte_idx_d = BYTE_HI;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_d = BIT_FIRST;
                        if (rw_q) begin
                            // R14: high byte sent first, low byte held
                            st_d = ST_TX;
                            shift_d = rd_word[15:8];
                            lo_hold_d = rd_word[7:0];
                            oe_n_d = rd_word[15];
                        end else begin
                            st_d = ST_RX;
                            oe_n_d = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        shift_d = {shift_q[6:0], 1'b0};
                        if (bit_cnt_q == BIT_LAST) begin
                            st_d = ST_MACK;
                            oe_n_d = 1'b1;
                        end else begin
                            oe_n_d = shift_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nack_d = sda_s;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            st_d = ST_IDLE;
                        end else begin
                            st_d = ST_TX;
                            bit_cnt_d = BIT_FIRST;
                            rd_lo_d = !rd_lo_q;
                            // Low byte comes from the snapshot so a word never tears
                            shift_d = rd_lo_q ? rd_word[15:8] : lo_hold_q;
                            oe_n_d = rd_lo_q ? rd_word[15] : lo_hold_q[7];
                            if (rd_lo_q) begin
                                lo_hold_d = rd_word[7:0];
                            end
                        end
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            bit_cnt_q <= BIT_FIRST;
            shift_q <= 8'h00;
            rx_full_q <= 1'b0;
            rw_q <= 1'b0;
            byte_idx_q <= BYTE_PTR;
            hi_q <= 8'h00;
            ptr_q <= PTR_RESET;
            lo_hold_q <= 8'h00;
            oe_n_q <= 1'b1;
            rd_lo_q <= 1'b0;
            nack_q <= 1'b0;
        end else if (ce_i) begin
            st_q <= st_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            rx_full_q <= rx_full_d;
            rw_q <= rw_d;
            byte_idx_q <= byte_idx_d;
            hi_q <= hi_d;
            ptr_q <= ptr_d;
            lo_hold_q <= lo_hold_d;
            oe_n_q <= oe_n_d;
            rd_lo_q <= rd_lo_d;
            nack_q <= nack_d;
        end
    end

    // ------------------------------------------------------------------
    // Registers and conversion control
    // ------------------------------------------------------------------
    logic busy_q, busy_d, start_q, start_d, abort_q, abort_d, mask_exp;
    logic [3:0] range_q, range_d;
    logic long_q, long_d;
    logic [LUX_W-1:0] lux_q, lux_d;

    // R6: manual range with zeroing enabled hides exponent
    assign mask_exp = cfg_q[EZE_BIT] && (cfg_q[RANGE_MSB:RANGE_LSB] < RANGE_AUTO);

    always_comb begin
        result_d = result_q;
        cfg_d = cfg_q;
        busy_d = busy_q;
        start_d = 1'b0;
        abort_d = 1'b0;
        if (conv_done_i && busy_q) begin
            // R1: exponent over mantissa; R11: auto range reported as is
            result_d = {(mask_exp ? EXP_ZERO : conv_exp_i), conv_mant_i};
            cfg_d[OVF_BIT] = conv_ovf_i;
            if (cfg_q[MODE_MSB:MODE_LSB] == MODE_SINGLE) begin
                cfg_d[MODE_MSB:MODE_LSB] = MODE_SHUTDOWN;
                busy_d = 1'b0;
            end else begin
                start_d = 1'b1;
            end
        end
        if (cfg_wr) begin
            // R13: bit 8 keeps the device value
            cfg_d = {wdata[15:OVF_BIT+1], cfg_d[OVF_BIT], wdata[OVF_BIT-1:0]};
            // R8: abort whatever is running
            abort_d = busy_q;
            // R9: restart under the new settings
            busy_d = (wdata[MODE_MSB:MODE_LSB] != MODE_SHUTDOWN);
            start_d = busy_d;
        end
        // R10: range field steers the converter
        range_d = cfg_d[RANGE_MSB:RANGE_LSB];
        long_d = cfg_d[CT_BIT];
        // R3: R4: straight count weighted by two to the exponent
        lux_d = LUX_W'({LUX_PAD, result_d[MANT_MSB:0]} << result_d[EXP_MSB:EXP_LSB]);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            // R5: R7: reset values
            result_q <= RESULT_RESET;
            cfg_q <= CONFIG_RESET;
            busy_q <= 1'b0;
            start_q <= 1'b0;
            abort_q <= 1'b0;
            range_q <= CONFIG_RESET[RANGE_MSB:RANGE_LSB];
            long_q <= CONFIG_RESET[CT_BIT];
            lux_q <= '0;
        end else if (ce_i) begin
            result_q <= result_d;
            cfg_q <= cfg_d;
            busy_q <= busy_d;
            start_q <= start_d;
            abort_q <= abort_d;
            range_q <= range_d;
            long_q <= long_d;
            lux_q <= lux_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = oe_n_q;
    assign conv_start_o = start_q;
    assign conv_abort_o = abort_q;
    assign conv_range_o = range_q;
    assign conv_long_o = long_q;
    assign lux_centi_o = lux_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_result_load;
        ce_i && conv_done_i && busy_q && !mask_exp |=> result_q == {$past(conv_exp_i), $past(conv_mant_i)};
    endproperty
    a_result_load: assert property (p_result_load) else $error("result not loaded"); // R1
    property p_result_hold;
        !(conv_done_i && busy_q) |=> $stable(result_q);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed without conversion"); // R2
    property p_exp_mask;
        ce_i && conv_done_i && busy_q && mask_exp |=> result_q[EXP_MSB:EXP_LSB] == EXP_ZERO;
    endproperty
    a_exp_mask: assert property (p_exp_mask) else $error("exponent not zeroed"); // R6
    property p_abort;
        ce_i && cfg_wr && busy_q |=> conv_abort_o ##1 !conv_abort_o || !ce_i;
    endproperty
    a_abort: assert property (p_abort) else $error("missing abort pulse"); // R8
    property p_restart;
        ce_i && cfg_wr |=> conv_start_o == ($past(wdata[MODE_MSB:MODE_LSB]) != MODE_SHUTDOWN);
    endproperty
    a_restart: assert property (p_restart) else $error("restart wrong"); // R9
    property p_cfg_write;
        ce_i && cfg_wr && !conv_done_i |=> cfg_q == {$past(wdata[15:9]), $past(cfg_q[OVF_BIT]), $past(wdata[7:0])};
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("configuration write wrong"); // R13
    property p_range_out;
        ce_i ##1 ce_i |-> conv_range_o == cfg_q[RANGE_MSB:RANGE_LSB];
    endproperty
    a_range_out: assert property (p_range_out) else $error("range output stale"); // R10
    property p_ptr_keep;
        !(ce_i && ptr_wr) |=> $stable(ptr_q);
    endproperty
    a_ptr_keep: assert property (p_ptr_keep) else $error("pointer changed"); // R15
    property p_lux;
        ce_i ##1 ce_i |-> lux_centi_o == LUX_W'({LUX_PAD, result_q[MANT_MSB:0]} << result_q[EXP_MSB:EXP_LSB]);
    endproperty
    a_lux: assert property (p_lux) else $error("lux decode wrong"); // R4

    c_cfg_write: cover property (ce_i && cfg_wr);
    c_abort: cover property (ce_i && cfg_wr && busy_q);
    c_masked: cover property (ce_i && conv_done_i && busy_q && mask_exp);
    c_read_lo: cover property (st_q == ST_TX && rd_lo_q);
endmodule // light_result_config_registers
`default_nettype wire

/* light_result_config_registers_test.sv */
// Self-checking bench for the result and configuration registers
`timescale 1ns/1ps
`default_nettype none
module light_result_config_registers_test
    import light_sensor_pkg::*;
();
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic conv_done_i = 1'b0;
    logic conv_ovf_i = 1'b0;
    logic [3:0] conv_exp_i = 4'h0;
    logic [11:0] conv_mant_i = 12'h000;
    logic scl, sda_host, sda_o, sda_oe_n_o, conv_start_o, conv_abort_o, conv_long_o;
    logic [3:0] conv_range_o;
    logic [LUX_W-1:0] lux_centi_o;
    wire sda_line;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    int starts = 0;
    int aborts = 0;
    logic [15:0] cfg_m = CONFIG_RESET;
    logic [15:0] res_m = RESULT_RESET;
    logic busy_m = 1'b0;
    logic [15:0] rd;
    logic ack;

    // Open-drain data line with pull-up
    assign sda_line = sda_host & (sda_oe_n_o | sda_o);

    light_result_config_registers dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .conv_done_i(conv_done_i), .conv_exp_i(conv_exp_i),
        .conv_mant_i(conv_mant_i), .conv_ovf_i(conv_ovf_i), .conv_start_o(conv_start_o),
        .conv_abort_o(conv_abort_o), .conv_range_o(conv_range_o), .conv_long_o(conv_long_o),
        .lux_centi_o(lux_centi_o)
    );
    i2c_host_model host (.clk_sys_i(clk_sys_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_host));

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // Pulse counting and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        cycles++;
        if (conv_start_o === 1'b1) starts++;
        if (conv_abort_o === 1'b1) aborts++;
        if (cycles == 90000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Register access over the serial bus
    // ------------------------------------------------------------
    task automatic bus_wr(input logic [7:0] ptr, input logic full, input logic [15:0] d);
        logic a;
        host.start_cond();
        host.send_byte({TARGET_ADDR_DEFAULT, 1'b0}, a);
        host.send_byte(ptr, ack);
        a &= ack;
        if (full) begin
            host.send_byte(d[15:8], ack);
            a &= ack;
            host.send_byte(d[7:0], ack);
            a &= ack;
        end
        host.stop_cond();
        chk("write acks", 1, a);
    endtask
    // Read with whatever pointer the target still holds
    task automatic rd_again(input logic [15:0] exp);
        host.start_cond();
        host.send_byte({TARGET_ADDR_DEFAULT, 1'b1}, ack);
        chk("read ack", 1, ack);
        host.recv_byte(1'b0, rd[15:8]);
        host.recv_byte(1'b1, rd[7:0]);
        host.stop_cond();
        chk("read data", exp, rd);
    endtask
    task automatic rd_reg(input logic [7:0] p, input logic [15:0] exp);
        bus_wr(p, 1'b0, 16'h0000);
        rd_again(exp);
    endtask
    task automatic cfg_write(input logic [15:0] d);
        int s0;
        int a0;
        logic was_busy;
        s0 = starts;
        a0 = aborts;
        was_busy = busy_m;
        bus_wr(PTR_SENSOR_CONFIG, 1'b1, d);
        cfg_m = {d[15:9], cfg_m[OVF_BIT], d[7:0]};
        busy_m = (d[MODE_MSB:MODE_LSB] != MODE_SHUTDOWN);
        chk("abort pulses", was_busy, aborts - a0);
        chk("start pulses", busy_m, starts - s0);
        chk("range level", cfg_m[RANGE_MSB:RANGE_LSB], conv_range_o);
        chk("long level", cfg_m[CT_BIT], conv_long_o);
    endtask
    task automatic conv_finish(input logic [3:0] e, input logic [11:0] m, input logic o);
        int s0;
        s0 = starts;
        conv_exp_i = e;
        conv_mant_i = m;
        conv_ovf_i = o;
        conv_done_i = 1'b1;
        @(negedge clk_sys_i);
        conv_done_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        if (busy_m) begin
            res_m = {(cfg_m[EZE_BIT] && cfg_m[RANGE_MSB:RANGE_LSB] < RANGE_AUTO) ? EXP_ZERO : e, m};
            cfg_m[OVF_BIT] = o;
            if (cfg_m[MODE_MSB:MODE_LSB] == MODE_SINGLE) begin
                cfg_m[MODE_MSB:MODE_LSB] = MODE_SHUTDOWN;
                busy_m = 1'b0;
            end
        end
        chk("lux", int'(res_m[11:0]) << res_m[15:12], lux_centi_o);
        chk("restart", busy_m, starts - s0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hF2F9));
        repeat (16) @(negedge clk_sys_i);
        rst_i = 1'b0;
        @(negedge clk_sys_i);
        chk("range reset", RANGE_AUTO, conv_range_o);
        chk("lux reset", 0, lux_centi_o);
        chk("long reset", CONFIG_RESET[CT_BIT], conv_long_o);
        rd_reg(PTR_SENSOR_CONFIG, CONFIG_RESET);
        rd_reg(PTR_LIGHT_RESULT, RESULT_RESET);
        host.start_cond();
        host.send_byte({TARGET_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
        host.stop_cond();
        chk("foreign address", 0, ack);
        rd_reg(8'h05, UNMAPPED_READ);
        // Only legal range codes are written; bit 8 is always set in the attempt
        for (int r = 0; r < 12; r++) begin
            cfg_write({r[3:0], 1'b0, MODE_SINGLE, 1'b1, 5'h00, r[0], 2'h0});
            conv_finish(4'($urandom_range(11, 0)), 12'($urandom), 1'($urandom));
            rd_reg(PTR_LIGHT_RESULT, res_m);
            rd_reg(PTR_SENSOR_CONFIG, cfg_m);
        end
        cfg_write({RANGE_AUTO, 1'b1, 2'h2, 1'b0, 8'h04});
        conv_finish(4'hB, 12'hFFF, 1'b0);
        rd_reg(PTR_LIGHT_RESULT, 16'hBFFF);
        rd_again(16'hBFFF);
        // A finished conversion offered while the clock enable is low must be lost
        ce_i = 1'b0;
        conv_exp_i = 4'h1;
        conv_mant_i = 12'h001;
        conv_done_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        conv_done_i = 1'b0;
        ce_i = 1'b1;
        @(negedge clk_sys_i);
        chk("frozen lux", 32'h007FF800, lux_centi_o);
        conv_finish(4'h3, 12'h456, 1'b1);
        cfg_write({RANGE_AUTO, 1'b0, 2'h3, 1'b0, 8'h00});
        cfg_write({4'h5, 1'b0, MODE_SHUTDOWN, 1'b0, 8'h00});
        conv_finish(4'h7, 12'h89A, 1'b0);
        bus_wr(PTR_LIGHT_RESULT, 1'b1, 16'hFFFF);
        rd_reg(PTR_LIGHT_RESULT, res_m);
        rd_reg(PTR_SENSOR_CONFIG, cfg_m);
        rst_i = 1'b1;
        cfg_m = CONFIG_RESET;
        res_m = RESULT_RESET;
        busy_m = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        @(negedge clk_sys_i);
        chk("lux after reset", 0, lux_centi_o);
        chk("long after reset", cfg_m[CT_BIT], conv_long_o);
        chk("range after reset", cfg_m[RANGE_MSB:RANGE_LSB], conv_range_o);
        rd_again(res_m);
        rd_reg(PTR_SENSOR_CONFIG, cfg_m);
        complete_run();
    end
endmodule // light_result_config_registers_test
`default_nettype wire

/* light_sensor_pkg.sv */
// Constants and types shared by the light sensor register block
package light_sensor_pkg;

    // ------------------------------------------------------------------
    // Register pointers and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PTR_LIGHT_RESULT = 8'h00;
    localparam logic [7:0] PTR_SENSOR_CONFIG = 8'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'hC810;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 12;
    localparam int MANT_MSB = 11;
    localparam int RANGE_MSB = 15;
    localparam int RANGE_LSB = 12;
    localparam int CT_BIT = 11;
    localparam int MODE_MSB = 10;
    localparam int MODE_LSB = 9;
    localparam int OVF_BIT = 8;
    localparam int EZE_BIT = 2;
    localparam logic [3:0] RANGE_AUTO = 4'hC;
    localparam logic [3:0] EXP_ZERO = 4'h0;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;

    // ------------------------------------------------------------------
    // Lux decode: one count of exponent 0 weighs 0.01 lux (one centilux)
    // ------------------------------------------------------------------
    localparam int LUX_W = 23;
    localparam logic [10:0] LUX_PAD = 11'h000;

    // ------------------------------------------------------------------
    // Serial bus
    // ------------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h44;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] BYTE_PTR = 2'h0;
    localparam logic [1:0] BYTE_HI = 2'h1;
    localparam logic [1:0] BYTE_LO = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RX,
        ST_TX,
        ST_MACK
    } bus_state_e;

endpackage
